// *** logic/pmc_pkg.sv ***
package pmc_pkg;

  // ************************************************************
  // Register map (byte addresses on the Wishbone slave).
  // ************************************************************
  localparam logic [7:0] PMC_OFS_STATUS = 8'h00;
  localparam logic [7:0] PMC_OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0] PMC_OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0] PMC_OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] PMC_OFS_IRQ_FLAG = 8'h10;
  localparam logic [7:0] PMC_OFS_STATE = 8'h14;

  // ************************************************************
  // Status word field positions.
  // ************************************************************
  localparam int PMC_SR_C = 0;
  localparam int PMC_SR_Z = 1;
  localparam int PMC_SR_N = 2;
  localparam int PMC_SR_GIE = 3;
  localparam int PMC_SR_CPU_CLOCK_OFF = 4;
  localparam int PMC_SR_FIRST_CRYSTAL_OFF = 5;
  localparam int PMC_SR_DC_GENERATOR_OFF = 6;
  localparam int PMC_SR_SUBSYS_CLOCK_OFF = 7;
  localparam int PMC_SR_V = 8;
  localparam logic [15:0] PMC_SR_MASK = 16'h01ff;
  localparam logic [15:0] PMC_SR_RST = 16'h0000;
  localparam logic [15:0] PMC_SR_WAKE_CLR = 16'h00f8;

  // ************************************************************
  // Clock control one: resistor select, external resistor, crystal bits.
  // ************************************************************
  localparam int PMC_C1_RSEL = 0;
  localparam int PMC_C1_EXTR = 3;
  localparam int PMC_C1_XTS = 6;
  localparam int PMC_C1_SECOND_CRYSTAL_DISABLE_POS = 7;
  localparam logic [7:0] PMC_C1_RST = 8'h84;
  localparam logic [7:0] PMC_C1_MASK = 8'hcf;

  // Clock control two: main select [1:0], subsystem select bit 2.
  localparam int PMC_C2_MAIN_CLOCK_SELECT = 0;
  localparam int PMC_C2_SUBSYS_CLOCK_SELECT = 2;
  localparam logic [7:0] PMC_C2_RST = 8'h00;
  localparam logic [7:0] PMC_C2_MASK = 8'h07;

  // Interrupt enable one and flag one layouts.
  localparam int PMC_IE_WDT = 0;
  localparam int PMC_IE_OF = 1;
  localparam int PMC_IE_NMI = 4;
  localparam int PMC_IE_ACCV = 5;
  localparam logic [7:0] PMC_IE_MASK = 8'hf3;
  localparam logic [7:0] PMC_IE_RST = 8'h00;
  localparam int PMC_IF_OF = 1;
  localparam int PMC_IF_NMI = 4;
  localparam int PMC_IF_ACCV = 5;
  localparam logic [7:0] PMC_IF_RST = 8'h00;

  // ************************************************************
  // Main clock source codes and vector table.
  // ************************************************************
  typedef enum logic [1:0] {
    PMC_MSRC_DCO0 = 2'b00,
    PMC_MSRC_DCO1 = 2'b01,
    PMC_MSRC_XT2 = 2'b10,
    PMC_MSRC_XT1 = 2'b11
  } pmc_msrc_e;

  localparam logic [15:0] PMC_VEC_BASE = 16'hffe0;
  localparam logic [3:0] PMC_PRIO_RESET = 4'hf;
  localparam logic [3:0] PMC_PRIO_NMI = 4'he;
  localparam int PMC_NUM_SRC = 16;
  localparam int PMC_NUM_MASK = 13;
  localparam int PMC_SYNC_LEN = 3;

endpackage

// *** logic/pmc_irq_if.sv ***
`timescale 1ns/1ps
// Request lines into the priority arbiter and its selection back.
interface pmc_irq_if;
  logic [15:0] req;
  logic valid;
  logic [3:0] prio;
  logic [15:0] vector;
  modport arb (input req, output valid, output prio, output vector);
  modport core (output req, input valid, input prio, input vector);
endinterface

// *** logic/pmc_irq_arb.sv ***
`timescale 1ns/1ps
module pmc_irq_arb
  import pmc_pkg::*;
(
  pmc_irq_if.arb irq
);

  // ************************************************************
  // Fixed priority select.
  // ************************************************************

  // Highest request index wins; index equals the priority number.
  logic [3:0] win;
  always_comb begin
    win = 4'h0;
    for (int i = 0; i < PMC_NUM_SRC; i++) begin
      if (irq.req[i]) begin
        win = 4'(i);
      end
    end
  end

  // Each entry is one word, so the vector is base plus twice the priority.
  assign irq.valid = |irq.req;
  assign irq.prio = win;
  assign irq.vector = PMC_VEC_BASE | {11'h000, win, 1'b0};

endmodule

// *** logic/pmc_top.sv ***
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Function
// - Interrupt wakes system, return restores prior mode
// - Provide auxiliary, main and subsystem clocks
// - Any of three oscillators can drive clocks
// - Crystal select bit picks high-frequency first crystal
// - Second crystal stop bit in control one
// - Generator trimmed in eight resistor steps, external option
// - Reset selects internal oscillator as main clock
// - Failed crystal forces main clock to internal oscillator
// - Oscillator failure sets fault flag, requests NMI
// - Status word layout, bits fifteen to nine reserved
// - Accept pushes status word, return pops it
// - CPU-off bit stops the main clock
// - Subsystem-off bit stops the subsystem clock
// - First crystal stops only if off and unused
// - Generator stops only if off and oscillator unused
// - Internal oscillator in use for main or subsystem
// - Vectors occupy one word each, FFE0h to FFFFh
// - All reset sources fetch top vector, priority fifteen
// - NMI, fault, violation share FFFCh with enables
// - Maskable sources on descending vectors, priorities 13..1
// - Nonmaskable sources ignore the global enable bit
// - Unassigned register bits hold no storage; interrupt enable bits 7:6 are stored
// - Fault enable bit gates fault request, resets zero
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_irq_accept_i,
  input wire logic cpu_return_from_irq_i,
  input wire logic [15:0] cpu_pop_word_i,
  output logic [15:0] cpu_push_word_o,
  output logic [15:0] cpu_status_word_o,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic [3:0] irq_prio_o,
  input wire logic nmi_pin_i,
  input wire logic xt1_fault_i,
  input wire logic xt2_fault_i,
  input wire logic flash_access_viol_i,
  input wire logic [2:0] reset_src_i,
  input wire logic [12:0] maskable_irq_i,
  output logic aclk_run_o,
  output logic mclk_run_o,
  output logic subsystem_clock_run_o,
  output logic [1:0] mclk_src_o,
  output logic subsystem_clock_src_o,
  output logic first_crystal_run_o,
  output logic crystal_hf_select_o,
  output logic second_crystal_run_o,
  output logic internal_osc_run_o,
  output logic dc_generator_run_o,
  output logic [2:0] dco_resistor_sel_o,
  output logic dco_ext_resistor_o,
  output logic forced_clock_o
);

  // ************************************************************
  // Registers.
  // ************************************************************
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_one_nxt;
  logic [7:0] ctrl_two_r;
  logic [7:0] ctrl_two_nxt;
  logic [7:0] irq_en_r;
  logic [7:0] irq_en_nxt;
  logic [7:0] irq_flag_r;
  logic [7:0] irq_flag_nxt;
  logic reset_pend_r;
  logic [15:0] push_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [15:0] vec_r;
  logic [3:0] prio_r;

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************

  // Three stages per pin; a change is taken only when stages two and three
  // agree, which rejects a single-cycle glitch at the cost of latency.
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s3_r;
  logic [2:0] pin_r;
  logic [2:0] pin_prev_r;
  assign pin_raw = {xt2_fault_i, xt1_fault_i, nmi_pin_i};

  genvar g;
  generate
    for (g = 0; g < PMC_SYNC_LEN; g++) begin : gen_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_s1_r[g] <= 1'b0;
          pin_s2_r[g] <= 1'b0;
          pin_s3_r[g] <= 1'b0;
          pin_r[g] <= 1'b0;
          pin_prev_r[g] <= 1'b0;
        end else begin
          pin_s1_r[g] <= pin_raw[g];
          pin_s2_r[g] <= pin_s1_r[g];
          pin_s3_r[g] <= pin_s2_r[g];
          pin_prev_r[g] <= pin_r[g];
          if (pin_s2_r[g] == pin_s3_r[g]) begin
            pin_r[g] <= pin_s3_r[g];
          end
        end
      end
    end
  endgenerate

  // Filtered pin levels and the rising edge of the NMI pin.
  logic nmi_pin_rise;
  logic xt1_failed;
  logic xt2_failed;
  assign nmi_pin_rise = pin_r[0] & ~pin_prev_r[0];
  assign xt1_failed = pin_r[1];
  assign xt2_failed = pin_r[2];

  // ************************************************************
  // Clock system.
  // ************************************************************

  // Status word power bits.
  logic cpu_clock_off;
  logic first_crystal_off;
  logic dc_generator_off;
  logic subsys_clock_off;
  logic global_irq_enable;
  assign cpu_clock_off = status_r[PMC_SR_CPU_CLOCK_OFF];
  assign first_crystal_off = status_r[PMC_SR_FIRST_CRYSTAL_OFF];
  assign dc_generator_off = status_r[PMC_SR_DC_GENERATOR_OFF];
  assign subsys_clock_off = status_r[PMC_SR_SUBSYS_CLOCK_OFF];
  assign global_irq_enable = status_r[PMC_SR_GIE];

  // Software selections from the control registers.
  logic [1:0] main_clock_select;
  logic subsys_clock_select;
  logic crystal_hf_select;
  logic second_crystal_disable;
  assign main_clock_select = ctrl_two_r[PMC_C2_MAIN_CLOCK_SELECT +: 2];
  assign subsys_clock_select = ctrl_two_r[PMC_C2_SUBSYS_CLOCK_SELECT];
  assign crystal_hf_select = ctrl_one_r[PMC_C1_XTS];
  assign second_crystal_disable = ctrl_one_r[PMC_C1_SECOND_CRYSTAL_DISABLE_POS];

  // A failed crystal that feeds the main clock hands it to the internal
  // oscillator, otherwise the fault handler itself could never run.
  logic forced;
  logic [1:0] main_src_eff;
  assign forced = ((main_clock_select == PMC_MSRC_XT1) & xt1_failed) |
                  ((main_clock_select == PMC_MSRC_XT2) & xt2_failed);
  assign main_src_eff = forced ? PMC_MSRC_DCO0 : main_clock_select;

  // Usage terms of the internal oscillator and the first crystal.
  logic dco_for_main;
  logic dco_for_sub;
  logic dco_in_use;
  logic xt1_for_main;
  logic irq_pending;
  assign dco_for_main = ~cpu_clock_off & ~main_src_eff[1];
  assign dco_for_sub = ~subsys_clock_off & ~subsys_clock_select;
  assign dco_in_use = dco_for_main | dco_for_sub | forced;
  assign xt1_for_main = (main_src_eff == PMC_MSRC_XT1);

  // Clock run enables; the main clock also runs while a request waits so
  // the core can take it and leave its low-power mode.
  assign aclk_run_o = first_crystal_run_o;
  assign mclk_run_o = ~cpu_clock_off | irq_pending;
  assign subsystem_clock_run_o = ~subsys_clock_off;
  assign mclk_src_o = main_src_eff;
  assign subsystem_clock_src_o = subsys_clock_select;
  assign first_crystal_run_o = ~first_crystal_off | xt1_for_main;
  assign crystal_hf_select_o = crystal_hf_select;
  assign second_crystal_run_o = ~second_crystal_disable |
                                (main_src_eff == PMC_MSRC_XT2);
  assign internal_osc_run_o = dco_in_use;
  assign dc_generator_run_o = ~dc_generator_off | dco_in_use;
  assign dco_resistor_sel_o = ctrl_one_r[PMC_C1_RSEL +: 3];
  assign dco_ext_resistor_o = ctrl_one_r[PMC_C1_EXTR];
  assign forced_clock_o = forced;

  // ************************************************************
  // Interrupt requests.
  // ************************************************************

  // The three shared sources are gated only by their own enables.
  logic nmi_req;
  assign nmi_req = (irq_flag_r[PMC_IF_NMI] & irq_en_r[PMC_IE_NMI]) |
                   (irq_flag_r[PMC_IF_OF] & irq_en_r[PMC_IE_OF]) |
                   (irq_flag_r[PMC_IF_ACCV] & irq_en_r[PMC_IE_ACCV]);

  // Request vector: index is the priority, gated maskables below.
  pmc_irq_if irq_bus();
  assign irq_bus.req = {reset_pend_r,
                        nmi_req,
                        maskable_irq_i & {PMC_NUM_MASK{global_irq_enable}},
                        1'b0};

  pmc_irq_arb u_arb (
    .irq(irq_bus)
  );

  assign irq_pending = irq_bus.valid;
  assign irq_req_o = irq_bus.valid;
  assign irq_vector_o = vec_r;
  assign irq_prio_o = prio_r;
  assign cpu_push_word_o = push_r;
  assign cpu_status_word_o = status_r;

  // Arbiter result registered so the vector is stable for the core.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_r <= PMC_VEC_BASE;
      prio_r <= 4'h0;
    end else begin
      vec_r <= irq_bus.vector;
      prio_r <= irq_bus.prio;
    end
  end

  // Power-up reset and every other reset source latch a request for the top vector;
  // taking it clears the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_pend_r <= 1'b1;
    end else if (|reset_src_i) begin
      reset_pend_r <= 1'b1;
    end else if (cpu_irq_accept_i && prio_r == PMC_PRIO_RESET) begin
      reset_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // Wishbone slave.
  // ************************************************************
  logic wb_req;
  logic wb_wr;
  logic hit_status;
  logic hit_one;
  logic hit_two;
  logic hit_en;
  logic hit_flag;
  logic hit_state;
  logic [31:0] rd_mux;
  logic [15:0] wmask16;
  logic [7:0] wmask8;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & ack_r;
  assign hit_status = (wb_adr_i == PMC_OFS_STATUS);
  assign hit_one = (wb_adr_i == PMC_OFS_CTRL_ONE);
  assign hit_two = (wb_adr_i == PMC_OFS_CTRL_TWO);
  assign hit_en = (wb_adr_i == PMC_OFS_IRQ_EN);
  assign hit_flag = (wb_adr_i == PMC_OFS_IRQ_FLAG);
  assign hit_state = (wb_adr_i == PMC_OFS_STATE);
  assign wmask16 = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wmask8 = {8{wb_sel_i[0]}};

  // Read selection; unmapped addresses read as zero.
  assign rd_mux = hit_status ? {16'h0000, status_r & PMC_SR_MASK} :
                  hit_one ? {24'h000000, ctrl_one_r} :
                  hit_two ? {24'h000000, ctrl_two_r} :
                  hit_en ? {24'h000000, irq_en_r} :
                  hit_flag ? {24'h000000, irq_flag_r} :
                  hit_state ? {vec_r, 4'h0, prio_r, 5'h00, dco_in_use, forced, irq_pending} :
                  32'h00000000;

  // Ack one cycle after the request; writes land on the edge that the
  // master samples the ack, so master and slave agree on that edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= wb_req & ~ack_r;
      rdata_r <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ************************************************************
  // Status word: accept, return and software writes.
  // ************************************************************

  // Accepting a request wakes the core; return loads the popped word.
  // The core's own events outrank a bus write in the same cycle.
  always_comb begin
    status_nxt = status_r;
    if (cpu_irq_accept_i) begin
      status_nxt = status_r & ~PMC_SR_WAKE_CLR;
    end else if (cpu_return_from_irq_i) begin
      status_nxt = cpu_pop_word_i & PMC_SR_MASK;
    end else if (wb_wr && hit_status) begin
      status_nxt = ((status_r & ~wmask16) | (wb_dat_i[15:0] & wmask16)) & PMC_SR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= PMC_SR_RST;
      push_r <= PMC_SR_RST;
    end else begin
      status_r <= status_nxt;
      if (cpu_irq_accept_i) begin
        push_r <= status_r;
      end
    end
  end

  // ************************************************************
  // Control and enable registers.
  // ************************************************************

  // Only implemented bits and interrupt enable bits 7:6 are stored; the others are constant zero.
  always_comb begin
    ctrl_one_nxt = ctrl_one_r;
    ctrl_two_nxt = ctrl_two_r;
    irq_en_nxt = irq_en_r;
    if (wb_wr && hit_one) begin
      ctrl_one_nxt = ((ctrl_one_r & ~wmask8) | (wb_dat_i[7:0] & wmask8)) & PMC_C1_MASK;
    end
    if (wb_wr && hit_two) begin
      ctrl_two_nxt = ((ctrl_two_r & ~wmask8) | (wb_dat_i[7:0] & wmask8)) & PMC_C2_MASK;
    end
    if (wb_wr && hit_en) begin
      irq_en_nxt = ((irq_en_r & ~wmask8) | (wb_dat_i[7:0] & wmask8)) & PMC_IE_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_r <= PMC_C1_RST;
      ctrl_two_r <= PMC_C2_RST;
      irq_en_r <= PMC_IE_RST;
    end else begin
      ctrl_one_r <= ctrl_one_nxt;
      ctrl_two_r <= ctrl_two_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // ************************************************************
  // Nonmaskable flags.
  // ************************************************************

  // Software clears a flag by writing one to it; a source event in the
  // same cycle wins, so no event is lost. The fault flag re-sets while
  // either crystal still reports a failure.
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  assign flag_set = {2'b00,
                     flash_access_viol_i,
                     nmi_pin_rise,
                     2'b00,
                     xt1_failed | xt2_failed,
                     1'b0};
  assign flag_clr = (wb_wr && hit_flag) ? (wb_dat_i[7:0] & wmask8) : 8'h00;

  always_comb begin
    irq_flag_nxt = ((irq_flag_r & ~flag_clr) | flag_set) & 8'h32;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_r <= PMC_IF_RST;
    end else begin
      irq_flag_r <= irq_flag_nxt;
    end
  end

endmodule

// *** verif/pmc_properties.sv ***
`timescale 1ns/1ps
// ************************************************************
// Port checker for the clock and vector block.
// ************************************************************
module pmc_top_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cpu_irq_accept_i,
  input wire logic cpu_return_from_irq_i,
  input wire logic [15:0] cpu_pop_word_i,
  input wire logic [15:0] cpu_push_word_o,
  input wire logic [15:0] cpu_status_word_o,
  input wire logic irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [3:0] irq_prio_o,
  input wire logic mclk_run_o,
  input wire logic subsystem_clock_run_o,
  input wire logic [1:0] mclk_src_o,
  input wire logic subsystem_clock_src_o,
  input wire logic first_crystal_run_o,
  input wire logic internal_osc_run_o,
  input wire logic dc_generator_run_o,
  input wire logic forced_clock_o
);
  // Oscillator in use for a running main or subsystem clock.
  wire [15:0] s = cpu_status_word_o;
  wire dco_need = (!s[4] && !mclk_src_o[1]) || (!s[7] && !subsystem_clock_src_o);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_sr_reserved: assert property (s[15:9] == 7'h00)
    else $error("status reserved bits set");
  a_mclk_gate: assert property (mclk_run_o == (!s[4] || irq_req_o))
    else $error("main clock gate wrong");
  a_sclk_gate: assert property (subsystem_clock_run_o == !s[7])
    else $error("subsystem clock gate wrong");
  a_xt1_kept: assert property (!s[5] || mclk_src_o == 2'b11 |-> first_crystal_run_o)
    else $error("first crystal stopped while needed");
  a_dco_kept: assert property (dco_need |-> internal_osc_run_o && dc_generator_run_o)
    else $error("oscillator stopped in use");
  a_dcgen_on: assert property (!s[6] |-> dc_generator_run_o)
    else $error("generator stopped while enabled");
  a_forced_dco: assert property (forced_clock_o |-> !mclk_src_o[1] && internal_osc_run_o && dc_generator_run_o)
    else $error("forced mode source wrong");
  a_accept_wake: assert property (cpu_irq_accept_i |=> s[7:3] == 5'h00
    && cpu_push_word_o == $past(s))
    else $error("accept did not push and wake");
  a_return_pop: assert property (cpu_return_from_irq_i && !cpu_irq_accept_i
    |=> s == ($past(cpu_pop_word_i) & 16'h01ff))
    else $error("return did not restore status");
  a_vector_prio: assert property (irq_vector_o == 16'hffe0 + {11'h000, irq_prio_o, 1'b0})
    else $error("vector does not match priority");
  a_reset_vector: assert property ($fell(rst_i) |=> irq_prio_o == 4'hf && !mclk_src_o[1])
    else $error("reset vector or source wrong");
  c_nmi_taken: cover property (cpu_irq_accept_i && irq_prio_o == 4'he);
  c_forced: cover property (forced_clock_o);
  c_return: cover property (cpu_return_from_irq_i);
endmodule

bind pmc_top pmc_top_checker chk (.*);

// *** verif/pmc_cpu_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Core model: take a request, return later.
// ************************************************************
module pmc_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire logic req_i,
  input wire logic [3:0] wait_i,
  input wire logic [15:0] push_i,
  input wire logic [15:0] mod_i,
  output logic accept_o,
  output logic ret_o,
  output logic [15:0] pop_o
);
  logic busy_r;
  logic req_d_r;
  logic [3:0] cnt_r;
  // The vector lags the request, so take it on its second cycle.
  always_ff @(posedge clk_i) begin
    accept_o <= 1'b0;
    ret_o <= 1'b0;
    pop_o <= ~pop_o; // Junk outside a return.
    req_d_r <= req_i;
    if (rst_i) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      pop_o <= 16'h5a5a;
    end else if (!busy_r && take_i && req_i && req_d_r) begin
      accept_o <= 1'b1;
      busy_r <= 1'b1;
      cnt_r <= wait_i;
    end else if (busy_r && !accept_o) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0) begin
        ret_o <= 1'b1;
        pop_o <= push_i ^ mod_i; // A handler may edit the stacked copy.
        busy_r <= 1'b0;
      end
    end
  end
endmodule

// *** verif/tb_pmc_top.sv ***
`timescale 1ns/1ps
module tb_pmc_top;
  import pmc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0, nmi = 1'b0, xt1f = 1'b0, xt2f = 1'b0, accv = 1'b0, take = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat;
  logic [3:0] sel = 4'h0, dly = 4'h0, prio;
  logic [2:0] rsrc = 3'h0, rsel;
  logic [12:0] mirq = 13'h0;
  logic [15:0] mod = 16'h0, pop, push, sr, vec, r;
  logic [15:0] seed = 16'd56;
  logic ack, acc, ret, req, mrun, srun, xt2run, hf, forced, ssrc;
  logic [1:0] msrc;
  logic [31:0] rq[$];
  logic [7:0] ofs[4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  logic [31:0] msk[4] = '{32'h1ff, 32'hcf, 32'h7, 32'hf3};
  int miscompares = 0;
  int total_checks = 0;
  int i;
  always #4 clk_i = ~clk_i;
  pmc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_irq_accept_i(acc),
    .cpu_return_from_irq_i(ret), .cpu_pop_word_i(pop), .cpu_push_word_o(push), .cpu_status_word_o(sr),
    .irq_req_o(req), .irq_vector_o(vec), .irq_prio_o(prio), .nmi_pin_i(nmi), .xt1_fault_i(xt1f),
    .xt2_fault_i(xt2f), .flash_access_viol_i(accv), .reset_src_i(rsrc), .maskable_irq_i(mirq),
    .aclk_run_o(), .mclk_run_o(mrun), .subsystem_clock_run_o(srun), .mclk_src_o(msrc),
    .subsystem_clock_src_o(ssrc), .first_crystal_run_o(), .crystal_hf_select_o(hf),
    .second_crystal_run_o(xt2run), .internal_osc_run_o(), .dc_generator_run_o(), .dco_resistor_sel_o(rsel),
    .dco_ext_resistor_o(), .forced_clock_o(forced));
  pmc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .take_i(take), .req_i(req), .wait_i(dly), .push_i(push),
    .mod_i(mod), .accept_o(acc), .ret_o(ret), .pop_o(pop));
  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait for ack, accept or return.
  task automatic wait_hi(input int which);
    int n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (((which == 0) ? ack : (which == 1) ? acc : ret) !== 1'b1 && n < 60);
    if (n >= 60) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // Classic cycle held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h3;
    wait_hi(0);
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Core takes one request; its vector is checked.
  task automatic take_vec(input logic [15:0] e);
    rq.push_back({16'h0, e});
    take <= 1'b1;
    wait_hi(1);
    take <= 1'b0;
    wait_hi(2);
  endtask
  // Reads and vectors compare in arrival order.
  always @(posedge clk_i) begin
    if ((ack === 1'b1 && we === 1'b0) || acc === 1'b1) begin
      chk(acc === 1'b1 ? "vector" : "read", rq.pop_front(), acc === 1'b1 ? {16'h0, vec} : rdat);
    end
  end
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PMC_OFS_STATUS, 32'h0);
    rd(PMC_OFS_CTRL_TWO, 32'h0);
    rd(PMC_OFS_IRQ_EN, 32'h0);
    rd(8'h20, 32'h0);
    take_vec(16'hfffe);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      rd(ofs[i], {24'h0, PMC_C1_RST} & {32{i == 1}});
      bus(1'b1, ofs[i], 32'hffffffff);
      rd(ofs[i], msk[i]);
    end
    for (i = 0; i < 8; i++) begin
      r = xs();
      bus(1'b1, PMC_OFS_CTRL_ONE, {24'h0, r[7:3], i[2:0]});
      @(negedge clk_i);
      chk("rsel", 32'(i[2:0]), 32'(rsel));
      chk("hf", 32'(r[6]), 32'(hf));
      chk("xt2", 32'(!r[7]), 32'(xt2run));
    end
    // Source selection against random power bits.
    for (i = 0; i < 16; i++) begin
      r = xs();
      bus(1'b1, PMC_OFS_CTRL_TWO, {29'h0, r[2:0]});
      bus(1'b1, PMC_OFS_STATUS, {16'h0, r & 16'h01f7});
      @(negedge clk_i);
      chk("msrc", 32'(r[1:0]), 32'(msrc));
      chk("ssrc", 32'(r[2]), 32'(ssrc));
      chk("sclk", 32'(!r[7]), 32'(srun));
      chk("mclk", 32'(!r[4]), 32'(mrun));
    end
    $display("test clocks done");
    // Highest pending maskable source wins from a sleeping core.
    for (i = 0; i < 13; i++) begin
      bus(1'b1, PMC_OFS_STATUS, 32'h98);
      r = xs();
      mirq <= 13'(1 << i) | (r[12:0] & 13'((1 << i) - 1));
      dly <= r[3:0];
      mod <= (i == 12) ? 16'h0090 : 16'h0;
      take_vec(16'hffe2 + 16'(2 * i));
      rd(PMC_OFS_STATUS, (i == 12) ? 32'h08 : 32'h98);
      mirq <= 13'h0;
    end
    mod <= 16'h0;
    bus(1'b1, PMC_OFS_STATUS, 32'h0);
    mirq <= 13'h1fff;
    @(negedge clk_i);
    chk("masked", 32'h0, 32'(req));
    mirq <= 13'h0;
    $display("test maskable done");
    // Shared sources obey their own enables only.
    bus(1'b1, PMC_OFS_IRQ_EN, 32'h0);
    accv <= 1'b1;
    @(posedge clk_i);
    accv <= 1'b0;
    @(negedge clk_i);
    chk("viol_gated", 32'h0, 32'(req));
    bus(1'b1, PMC_OFS_IRQ_EN, 32'h20);
    take_vec(16'hfffc);
    bus(1'b1, PMC_OFS_IRQ_FLAG, 32'h20);
    nmi <= 1'b1;
    repeat (PMC_SYNC_LEN + 2) @(posedge clk_i);
    nmi <= 1'b0;
    bus(1'b1, PMC_OFS_IRQ_EN, 32'h10);
    take_vec(16'hfffc);
    bus(1'b1, PMC_OFS_IRQ_FLAG, 32'h10);
    bus(1'b1, PMC_OFS_IRQ_EN, 32'h0);
    // A failed main crystal forces the internal oscillator.
    for (i = 0; i < 2; i++) begin
      bus(1'b1, PMC_OFS_CTRL_TWO, {30'h0, 1'b1, i[0]});
      xt1f <= i[0];
      xt2f <= !i[0];
      repeat (PMC_SYNC_LEN + 2) @(posedge clk_i);
      @(negedge clk_i);
      chk("forced", 32'h1, 32'(forced));
      chk("msrc1", 32'h0, 32'(msrc[1]));
      chk("of_gated", 32'h0, 32'(req));
      rd(PMC_OFS_IRQ_FLAG, 32'h2);
      bus(1'b1, PMC_OFS_IRQ_EN, 32'h2);
      take_vec(16'hfffc);
      xt1f <= 1'b0;
      xt2f <= 1'b0;
      repeat (PMC_SYNC_LEN + 2) @(posedge clk_i);
      bus(1'b1, PMC_OFS_IRQ_FLAG, 32'h2);
      bus(1'b1, PMC_OFS_IRQ_EN, 32'h0);
      @(negedge clk_i);
      chk("msrc", {30'h0, 1'b1, i[0]}, 32'(msrc));
    end
    $display("test faults done");
    // Every reset source fetches the top vector.
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i);
      rsrc <= 3'(1 << i);
      @(posedge clk_i);
      rsrc <= 3'h0;
      take_vec(16'hfffe);
    end
    $display("test resets done");
    report_and_stop();
  end
endmodule
